// ==== rtl/rfc_pkg.sv ====
package rfc_pkg;
    // ***********************************************
    // Register map on the bus (byte addresses)
    // ***********************************************
    localparam int ADR_W = 8;
    localparam logic [7:0] OFS_GPR = 8'h00;
    localparam logic [7:0] OFS_GPR_END = 8'h3C;
    localparam logic [7:0] OFS_PSR = 8'h40;
    localparam logic [7:0] OFS_CFG = 8'h44;
    localparam logic [7:0] OFS_PC = 8'h48;
    localparam logic [7:0] OFS_INTR_SP = 8'h4C;
    localparam logic [7:0] OFS_USER_SP = 8'h50;
    localparam logic [7:0] OFS_DTB = 8'h54;

    // ***********************************************
    // Fields, reset values, masks
    // ***********************************************
    localparam logic [3:0] NARROW_CNT = 4'hC;
    localparam logic [3:0] SR_PAIR_LAST = 4'hD;
    localparam logic [3:0] SP_IDX = 4'hF;
    localparam int PSR_USER_BIT = 3;
    localparam int CFG_COMPAT_BIT = 9;
    localparam logic [15:0] PSR_RESET = 16'h0200;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [23:0] PC_START = 24'h00_0000;
    localparam logic [23:0] PC_MASK = 24'hFF_FFFE;
    localparam logic [31:0] INTR_SP_MASK = 32'h00FF_FFFE;
    localparam logic [31:0] USER_SP_LIMIT = 32'h00FF_FFFF;
    localparam logic [31:0] STACK_STEP = 32'h0000_0004;

    // ***********************************************
    // Carriers
    // ***********************************************
    typedef enum logic [1:0] {
        RFC_SZ_BYTE = 2'h0,
        RFC_SZ_WORD = 2'h1,
        RFC_SZ_DWORD = 2'h2
    } rfc_size_t;

    typedef struct packed {
        logic valid;
        logic we;
        rfc_size_t size;
        logic [3:0] idx;
        logic [31:0] wdata;
        logic pc_we;
        logic [23:0] pc_val;
    } rfc_op_t;

    typedef struct packed {
        logic valid;
        logic pop;
        logic exc;
    } rfc_stk_t;

    typedef struct packed {
        logic [15:0][31:0] gpr;
        logic [15:0] psr;
        logic [15:0] cfg;
        logic [23:0] pc;
        logic [31:0] intr_sp;
        logic [31:0] user_sp;
        logic [31:0] dtb;
        logic [31:0] rdata;
        logic [31:0] wb_rdata;
        logic ack;
        logic [31:0] stk_addr;
        logic stk_vld;
        logic trap;
    } rfc_state_t;
endpackage : rfc_pkg

// ==== rtl/rfc_regfile.sv ====
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module rfc_regfile
    import rfc_pkg::*;
#(
    parameter logic [23:0] START_PC = PC_START
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic warm_rst_i,
    input wire rfc_op_t op_i,
    input wire rfc_stk_t stk_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [31:0] rd_data_o,
    output logic [23:0] pc_o,
    output logic [31:0] dtb_o,
    output logic user_mode_bit_o,
    output logic short_register_compat_bit_o,
    output logic [31:0] stk_addr_o,
    output logic stk_valid_o,
    output logic illegal_address_trap_o
);
    // ***********************************************
    // State and combinational helpers
    // ***********************************************
    rfc_state_t st;
    rfc_state_t next_st;
    logic sr;
    logic user;
    logic paired;
    logic [3:0] hi_idx;
    logic [31:0] lo_reg;
    logic [31:0] hi_reg;
    logic [31:0] core_rd;
    logic [31:0] ptr;
    logic [31:0] new_ptr;
    logic wb_hit;
    logic [3:0] wb_idx;

    // Byte-lane merge for bus writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // Pairing decode and core read path
    always_comb begin
        sr = st.cfg[CFG_COMPAT_BIT];
        user = st.psr[PSR_USER_BIT];
        hi_idx = op_i.idx + 4'h1;
        // Compat mode pairs reach up to R14/R13 low halves
        paired = sr ? (op_i.idx <= SR_PAIR_LAST) : (op_i.idx < NARROW_CNT);
        lo_reg = st.gpr[op_i.idx];
        hi_reg = st.gpr[hi_idx];
        case (op_i.size)
            RFC_SZ_BYTE: core_rd = {24'h00_0000, lo_reg[7:0]};
            RFC_SZ_WORD: core_rd = {16'h0000, lo_reg[15:0]};
            RFC_SZ_DWORD: core_rd = paired ? {hi_reg[15:0], lo_reg[15:0]} : lo_reg;
            default: core_rd = 32'h0000_0000;
        endcase
    end

    // Stack pointer choice; exceptions always go to the interrupt stack pointer
    always_comb begin
        if (stk_i.exc) begin
            ptr = st.intr_sp;
        end else if (user) begin
            ptr = st.user_sp;
        end else begin
            ptr = st.gpr[SP_IDX];
        end
        // Stacks grow downward: push predecrements, pop postincrements
        new_ptr = stk_i.pop ? ptr + STACK_STEP : ptr - STACK_STEP;
    end

    // Bus is stalled while op_i.valid or stk_i.valid is set; a bus PC write still overrides an op_i.pc_we given without op_i.valid
    always_comb begin
        wb_hit = wb_cyc_i && wb_stb_i && !st.ack && !op_i.valid && !stk_i.valid;
        wb_idx = wb_adr_i[5:2];
    end

    // ***********************************************
    // Next-state logic
    // ***********************************************
    always_comb begin
        next_st = st;
        next_st.ack = 1'b0;
        next_st.trap = 1'b0;
        next_st.stk_vld = 1'b0;

        // Core register access
        if (op_i.valid && !op_i.we) begin
            next_st.rdata = core_rd;
        end
        if (op_i.valid && op_i.we) begin
            case (op_i.size)
                RFC_SZ_BYTE: next_st.gpr[op_i.idx][7:0] = op_i.wdata[7:0];
                RFC_SZ_WORD: next_st.gpr[op_i.idx][15:0] = op_i.wdata[15:0];
                RFC_SZ_DWORD: begin
                    if (paired) begin
                        // Both halves land on the same edge
                        next_st.gpr[op_i.idx][15:0] = op_i.wdata[15:0];
                        next_st.gpr[hi_idx][15:0] = op_i.wdata[31:16];
                    end else begin
                        next_st.gpr[op_i.idx] = op_i.wdata;
                    end
                end
                default: next_st.rdata = st.rdata;
            endcase
        end
        if (op_i.pc_we) begin
            next_st.pc = op_i.pc_val;
        end

        // Stack access, refused with a trap when the user pointer is out of range
        if (stk_i.valid) begin
            if (!stk_i.exc && user && st.user_sp > USER_SP_LIMIT) begin
                next_st.trap = 1'b1;
            end else begin
                next_st.stk_vld = 1'b1;
                next_st.stk_addr = stk_i.pop ? ptr : new_ptr;
                if (stk_i.exc) begin
                    next_st.intr_sp = new_ptr;
                end else if (user) begin
                    next_st.user_sp = new_ptr;
                end else begin
                    next_st.gpr[SP_IDX] = new_ptr;
                end
            end
        end

        // Bus slave: one wait state, unmapped reads zero, writes dropped
        if (wb_hit) begin
            next_st.ack = 1'b1;
            next_st.wb_rdata = 32'h0000_0000;
            if (wb_adr_i <= OFS_GPR_END) begin
                next_st.wb_rdata = st.gpr[wb_idx];
                if (wb_we_i) begin
                    next_st.gpr[wb_idx] = lane_merge(st.gpr[wb_idx], wb_dat_i, wb_sel_i);
                end
            end else begin
                case (wb_adr_i)
                    OFS_PSR: begin
                        next_st.wb_rdata = {16'h0000, st.psr};
                        if (wb_we_i) begin
                            next_st.psr = 16'(lane_merge({16'h0000, st.psr}, wb_dat_i,
                                                         wb_sel_i));
                        end
                    end
                    OFS_CFG: begin
                        next_st.wb_rdata = {16'h0000, st.cfg};
                        if (wb_we_i) begin
                            next_st.cfg = 16'(lane_merge({16'h0000, st.cfg}, wb_dat_i,
                                                         wb_sel_i));
                        end
                    end
                    OFS_PC: begin
                        next_st.wb_rdata = {8'h00, st.pc};
                        if (wb_we_i) begin
                            next_st.pc = 24'(lane_merge({8'h00, st.pc}, wb_dat_i,
                                                        wb_sel_i));
                        end
                    end
                    OFS_INTR_SP: begin
                        next_st.wb_rdata = st.intr_sp;
                        if (wb_we_i) begin
                            next_st.intr_sp = lane_merge(st.intr_sp, wb_dat_i, wb_sel_i);
                        end
                    end
                    OFS_USER_SP: begin
                        next_st.wb_rdata = st.user_sp;
                        if (wb_we_i) begin
                            next_st.user_sp = lane_merge(st.user_sp, wb_dat_i, wb_sel_i);
                        end
                    end
                    OFS_DTB: begin
                        // Stored as written; software keeps the must-be-zero bits
                        next_st.wb_rdata = st.dtb;
                        if (wb_we_i) begin
                            next_st.dtb = lane_merge(st.dtb, wb_dat_i, wb_sel_i);
                        end
                    end
                    default: next_st.wb_rdata = 32'h0000_0000;
                endcase
            end
        end

        // Narrow registers lose their upper half; reserved reads come back zero
        for (int i = 0; i < 12; i++) begin
            next_st.gpr[i][31:16] = 16'h0000;
        end
        next_st.pc = next_st.pc & PC_MASK;
        next_st.intr_sp = next_st.intr_sp & INTR_SP_MASK;

        // Warm reset wins over PC, PSR, CFG, stack valid and trap, and keeps the old PC in R1:R0
        if (warm_rst_i) begin
            next_st.gpr[0] = {16'h0000, st.pc[15:0]};
            next_st.gpr[1] = {24'h00_0000, st.pc[23:16]};
            next_st.pc = START_PC & PC_MASK;
            next_st.psr = PSR_RESET;
            next_st.cfg = CFG_RESET;
            next_st.stk_vld = 1'b0;
            next_st.trap = 1'b0;
        end
    end

    // ***********************************************
    // State register
    // ***********************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.psr <= PSR_RESET;
            st.cfg <= CFG_RESET;
            st.pc <= START_PC & PC_MASK;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    always_comb begin
        wb_dat_o = st.wb_rdata;
        wb_ack_o = st.ack;
        rd_data_o = st.rdata;
        pc_o = st.pc;
        dtb_o = st.dtb;
        user_mode_bit_o = st.psr[PSR_USER_BIT];
        short_register_compat_bit_o = st.cfg[CFG_COMPAT_BIT];
        stk_addr_o = st.stk_addr;
        stk_valid_o = st.stk_vld;
        illegal_address_trap_o = st.trap;
    end

    // ***********************************************
    // Assertions
    // ***********************************************
    sequence s_user_bad;
        stk_i.valid && !stk_i.exc && st.psr[PSR_USER_BIT] && st.user_sp > USER_SP_LIMIT
            && !warm_rst_i;
    endsequence

    sequence s_user_push;
        stk_i.valid && !stk_i.exc && !stk_i.pop && st.psr[PSR_USER_BIT]
            && st.user_sp <= USER_SP_LIMIT && !warm_rst_i;
    endsequence

    sequence s_exc_push;
        stk_i.valid && stk_i.exc && !stk_i.pop && !warm_rst_i;
    endsequence

    sequence s_sv_push;
        stk_i.valid && !stk_i.exc && !stk_i.pop && !st.psr[PSR_USER_BIT]
            && !warm_rst_i;
    endsequence

    pc_lsb_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !pc_o[0]) else $error("program counter bit 0 set");

    intr_sp_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.intr_sp[31:24] == 8'h00 && !st.intr_sp[0])
        else $error("interrupt stack pointer forced bits not zero");

    narrow_regs_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.gpr[11][31:16] == 16'h0000 && st.gpr[0][31:16] == 16'h0000)
        else $error("narrow register upper half set");

    warm_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        warm_rst_i |=> st.gpr[0][15:0] == $past(st.pc[15:0])
            && st.gpr[1][7:0] == $past(st.pc[23:16]) && pc_o == (START_PC & PC_MASK))
        else $error("warm reset did not save program counter");

    reset_pc_a: assert property (@(posedge clk_i)
        rst_i |=> pc_o == (START_PC & PC_MASK) && !wb_ack_o)
        else $error("program counter not at start value after reset");

    user_trap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_user_bad |=> illegal_address_trap_o && !stk_valid_o
            && st.user_sp == $past(st.user_sp)) else $error("bad user stack not trapped");

    user_push_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_user_push |=> stk_valid_o && st.user_sp == $past(st.user_sp) - STACK_STEP
            && stk_addr_o == st.user_sp) else $error("user push did not lower user pointer");

    intr_push_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exc_push |=> st.intr_sp == (($past(st.intr_sp) - STACK_STEP) & INTR_SP_MASK)
            && stk_addr_o == st.intr_sp) else $error("exception push did not lower pointer");

    sv_push_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_sv_push |=> st.gpr[SP_IDX] == $past(st.gpr[SP_IDX]) - STACK_STEP
            && st.user_sp == $past(st.user_sp))
        else $error("supervisor push used wrong pointer");

    // Paired reads join the two low halves, lower index in the low word
    pair_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        op_i.valid && !op_i.we && op_i.size == RFC_SZ_DWORD && paired && !warm_rst_i
        |=> rd_data_o == {$past(st.gpr[hi_idx][15:0]), $past(st.gpr[op_i.idx][15:0])})
        else $error("paired read did not join the low halves");

    byte_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        op_i.valid && op_i.we && op_i.size == RFC_SZ_BYTE && !warm_rst_i
            && op_i.idx != SP_IDX
        |=> st.gpr[$past(op_i.idx)][31:8] == $past(st.gpr[op_i.idx][31:8]))
        else $error("byte write disturbed upper bits");

    pair_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        op_i.valid && op_i.we && op_i.size == RFC_SZ_DWORD && paired && !warm_rst_i
            && op_i.idx > 4'h1
        |=> {st.gpr[$past(hi_idx)][15:0], st.gpr[$past(op_i.idx)][15:0]}
            == $past(op_i.wdata)) else $error("pair write split across cycles");

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("bus ack held longer than one cycle");
endmodule : rfc_regfile

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb
    import rfc_pkg::*;
;
    // ******************************************
    // Clock, stimulus and counters
    // ******************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic warm_rst_i = 1'b0;
    rfc_op_t op_i = '0;
    rfc_stk_t stk_i = '0;
    logic [ADR_W-1:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o, rd_data_o, dtb_o, stk_addr_o, rd;
    logic [23:0] pc_o;
    logic wb_ack_o, user_mode_bit_o, short_register_compat_bit_o, stk_valid_o;
    logic illegal_address_trap_o;
    int error_cnt = 0;
    int compares = 0;

    // 25 MHz core clock
    always #20 clk_i = ~clk_i;

    rfc_regfile u_rfc_regfile (.clk_i(clk_i), .rst_i(rst_i), .warm_rst_i(warm_rst_i),
        .op_i(op_i), .stk_i(stk_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rd_data_o(rd_data_o), .pc_o(pc_o),
        .dtb_o(dtb_o), .user_mode_bit_o(user_mode_bit_o),
        .short_register_compat_bit_o(short_register_compat_bit_o),
        .stk_addr_o(stk_addr_o), .stk_valid_o(stk_valid_o),
        .illegal_address_trap_o(illegal_address_trap_o));

    task automatic test_done;
        if (error_cnt == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // ******************************************
    // Bus, core and stack drivers
    // ******************************************
    // Classic single cycle; hangs are cut by the bounded wait
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 20) begin
            error_cnt++;
            test_done();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic core(input logic we, input rfc_size_t sz, input logic [3:0] idx,
                        input logic [31:0] d);
        @(posedge clk_i);
        op_i <= '{valid: 1'b1, we: we, size: sz, idx: idx, wdata: d, pc_we: 1'b0, pc_val: '0};
        @(posedge clk_i);
        op_i <= '0;
        #1;
    endtask : core

    task automatic stk(input logic pop, input logic exc, input logic vld, input logic trp,
                       input logic [31:0] adr);
        @(posedge clk_i);
        stk_i <= '{valid: 1'b1, pop: pop, exc: exc};
        @(posedge clk_i);
        stk_i <= '0;
        #1;
        `CHK("stack valid", vld, stk_valid_o)
        `CHK("trap", trp, illegal_address_trap_o)
        if (vld) `CHK("stack addr", adr, stk_addr_o)
    endtask : stk

    // ******************************************
    // Scenarios
    // ******************************************
    task automatic t_reset_and_widths;
        `CHK("pc after reset", 24'h00_0000, pc_o)
        wb(1'b0, OFS_PSR, '0);
        `CHK("psr reset", 32'h0000_0200, rd)
        wb(1'b1, OFS_GPR, 32'hFFFF_FFFF);
        wb(1'b0, OFS_GPR, '0);
        `CHK("r0 width", 32'h0000_FFFF, rd)
        wb(1'b1, 8'h30, 32'hFFFF_FFFF);
        wb(1'b0, 8'h30, '0);
        `CHK("r12 width", 32'hFFFF_FFFF, rd)
        wb(1'b1, OFS_PC, 32'hFFFF_FFFF);
        wb(1'b0, OFS_PC, '0);
        `CHK("pc width", 32'h00FF_FFFE, rd)
        wb(1'b1, OFS_INTR_SP, 32'hFFFF_FFFF);
        wb(1'b0, OFS_INTR_SP, '0);
        `CHK("intr sp mask", 32'h00FF_FFFE, rd)
        wb(1'b1, OFS_DTB, 32'h00AB_CDE0);
        `CHK("dispatch base", 32'h00AB_CDE0, dtb_o)
        wb(1'b1, 8'h60, 32'h1234_5678);
        wb(1'b0, 8'h60, '0);
        `CHK("unmapped", 32'h0000_0000, rd)
    endtask : t_reset_and_widths

    task automatic t_partial_and_pairs;
        wb(1'b1, 8'h0C, 32'h0000_1234);
        core(1'b1, RFC_SZ_BYTE, 4'h3, 32'hFFFF_FFAB);
        core(1'b0, RFC_SZ_WORD, 4'h3, '0);
        `CHK("byte write", 32'h0000_12AB, rd_data_o)
        core(1'b0, RFC_SZ_BYTE, 4'h3, '0);
        `CHK("byte read", 32'h0000_00AB, rd_data_o)
        core(1'b1, RFC_SZ_DWORD, 4'hA, 32'h1111_2222);
        wb(1'b0, 8'h2C, '0);
        `CHK("pair upper", 32'h0000_1111, rd)
        core(1'b1, RFC_SZ_WORD, 4'hA, 32'hFFFF_3333);
        core(1'b0, RFC_SZ_DWORD, 4'hA, '0);
        `CHK("word on pair", 32'h1111_3333, rd_data_o)
        core(1'b1, RFC_SZ_DWORD, 4'hC, 32'hAAAA_5555);
        wb(1'b0, 8'h34, '0);
        `CHK("r13 untouched", 32'h0000_0000, rd)
        wb(1'b1, 8'h38, 32'hCCCC_0000);
        wb(1'b1, OFS_CFG, 32'h0000_0200);
        `CHK("compat bit", 1'b1, short_register_compat_bit_o)
        core(1'b1, RFC_SZ_DWORD, 4'hD, 32'hAAAA_5555);
        wb(1'b0, 8'h38, '0);
        `CHK("ret pair high", 32'hCCCC_AAAA, rd)
        core(1'b0, RFC_SZ_DWORD, 4'hD, '0);
        `CHK("ret pair read", 32'hAAAA_5555, rd_data_o)
        wb(1'b1, OFS_CFG, 32'h0000_0000);
    endtask : t_partial_and_pairs

    task automatic t_stacks;
        wb(1'b1, 8'h3C, 32'h0000_0100);
        stk(1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_00FC);
        stk(1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_00FC);
        wb(1'b0, 8'h3C, '0);
        `CHK("sp restored", 32'h0000_0100, rd)
        wb(1'b1, OFS_INTR_SP, 32'h0000_0200);
        wb(1'b1, OFS_USER_SP, 32'h0000_0400);
        wb(1'b1, OFS_PSR, 32'h0000_0208);
        `CHK("user mode", 1'b1, user_mode_bit_o)
        stk(1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_03FC);
        stk(1'b0, 1'b1, 1'b1, 1'b0, 32'h0000_01FC);
        wb(1'b1, OFS_USER_SP, 32'h0100_0000);
        stk(1'b0, 1'b0, 1'b0, 1'b1, '0);
        wb(1'b0, OFS_USER_SP, '0);
        `CHK("user sp kept", 32'h0100_0000, rd)
        wb(1'b1, OFS_PSR, 32'h0000_0200);
    endtask : t_stacks

    task automatic t_warm;
        @(posedge clk_i);
        op_i <= '{valid: 1'b1, we: 1'b0, size: RFC_SZ_WORD, idx: 4'h0, wdata: '0,
                  pc_we: 1'b1, pc_val: 24'h12_3456};
        @(posedge clk_i);
        op_i <= '0;
        warm_rst_i <= 1'b1;
        @(posedge clk_i);
        warm_rst_i <= 1'b0;
        #1;
        `CHK("pc after warm", 24'h00_0000, pc_o)
        wb(1'b0, OFS_GPR, '0);
        `CHK("warm r0", 32'h0000_3456, rd)
        wb(1'b0, 8'h04, '0);
        `CHK("warm r1", 32'h0000_0012, rd)
    endtask : t_warm

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        t_reset_and_widths();
        t_partial_and_pairs();
        t_stacks();
        t_warm();
        test_done();
    end
endmodule : tb
